// ===== shared/pgt_pkg.sv
// types of the pattern generator frame timing block
// assumes nothing beyond a SystemVerilog compiler
package pgt_pkg;

   typedef enum logic [1:0] {
      PGT_RATE_400,
      PGT_RATE_800,
      PGT_RATE_1200,
      PGT_RATE_1600
   } pgt_rate_e;

   typedef enum logic [2:0] {
      S_IDLE,
      S_BACK,
      S_ACTIVE,
      S_FRONT,
      S_FILL
   } pgt_state_e;

   typedef struct packed {
      logic [15:0] acc;
      logic tick;
   } pgt_tick_s;

   typedef struct packed {
      logic [7:0] act_hi;
      logic [7:0] act_lo;
      logic [7:0] tot_hi;
      logic [7:0] tot_lo;
      logic [7:0] per_hi;
      logic [7:0] per_lo;
      logic [7:0] vbp;
      logic [7:0] vfp;
      logic en;
      logic [7:0] rdata;
      pgt_state_e st;
      logic [15:0] act_c;
      logic [15:0] tot_c;
      logic [15:0] per_c;
      logic [7:0] vbp_c;
      logic [7:0] vfp_c;
      logic [15:0] line_idx;
      logic [15:0] seg_cnt;
      logic [15:0] unit_cnt;
      logic fe_done;
      logic fs;
      logic fe;
      logic ls;
      logic lv;
      logic vb;
      logic busy;
   } pgt_core_s;

endpackage

// ===== shared/pgt_regs.svh
// register offsets, reset values and timing figures of the frame timing block
// assumes an 8-bit indirect register port and a 200 MHz core clock
`ifndef PGT_REGS_SVH
`define PGT_REGS_SVH

`define PGT_ADDR_CTL 8'h01
`define PGT_ADDR_ACT_HI 8'h08
`define PGT_ADDR_ACT_LO 8'h09
`define PGT_ADDR_TOT_HI 8'h0a
`define PGT_ADDR_TOT_LO 8'h0b
`define PGT_ADDR_PER_HI 8'h0c
`define PGT_ADDR_PER_LO 8'h0d
`define PGT_ADDR_VBP 8'h0e
`define PGT_ADDR_VFP 8'h0f

`define PGT_CTL_EN_BIT 0

`define PGT_RST_ACT_HI 8'h01
`define PGT_RST_ACT_LO 8'he0
`define PGT_RST_TOT_HI 8'h02
`define PGT_RST_TOT_LO 8'h0d
`define PGT_RST_PER_HI 8'h0c
`define PGT_RST_PER_LO 8'h67
`define PGT_RST_VBP 8'h21
`define PGT_RST_VFP 8'h0a
`define PGT_RST_EN 1'b0

// clock period and line period units, in picoseconds
`define PGT_CLK_PS 5000
`define PGT_UNIT_10NS_PS 10000
`define PGT_UNIT_13NS_PS 13333
`define PGT_UNIT_20NS_PS 20000

`endif

// ===== sim/pgt_rx_model.sv
// receiver side model: counts the lines of each frame as the downstream processor sees them
// assumes the frame timing outputs live in the mclk domain
`timescale 1ns/1ps
module pgt_rx_model (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic frame_start,
   input wire logic frame_end,
   input wire logic line_start,
   input wire logic line_active,
   input wire logic vert_blank,
   input wire logic frame_busy,
   output logic [15:0] n_back,
   output logic [15:0] n_act,
   output logic [15:0] n_front,
   output logic [15:0] n_tot,
   output logic [15:0] len_min,
   output logic [15:0] len_max,
   output logic [15:0] n_frames
);
   logic [15:0] cyc, last, t, b, a, f, len;
   logic seen, ended, busy_d;
   always @(posedge mclk)
   begin
      if (!nrst)
      begin
         {cyc, last, t, b, a, f, n_back, n_act, n_front, n_tot, len_max, n_frames} = '0;
         {seen, ended, busy_d} = '0;
         len_min = 16'hffff;
      end
      else
      begin
         cyc = cyc + 16'h1;
         if (frame_start)
         begin
            n_frames = n_frames + 16'h1;
            {t, b, a, f, len_max, seen, ended} = '0;
            len_min = 16'hffff;
         end
         // the last line ends where busy drops, not at a later line start
         if ((line_start || (busy_d && !frame_busy)) && t != 16'h0)
         begin
            len = cyc - last;
            if (len < len_min)
               len_min = len;
            if (len > len_max)
               len_max = len;
         end
         if (busy_d && !frame_busy)
            n_tot = t;
         // a line start that comes with frame end already belongs to the fill
         if (line_start && !ended && !frame_end)
         begin
            if (line_active)
            begin
               a = a + 16'h1;
               seen = 1'b1;
            end
            else if (vert_blank && seen)
               f = f + 16'h1;
            else if (vert_blank)
               b = b + 16'h1;
         end
         if (frame_end)
         begin
            ended = 1'b1;
            {n_back, n_act, n_front} = {b, a, f};
         end
         if (line_start)
         begin
            t = t + 16'h1;
            last = cyc;
         end
         busy_d = frame_busy;
      end
   end
endmodule

// ===== sim/test_pgt_frame_timing.sv
// self-checking bench of the frame timing block with a receiver model
// assumes the register map and reset values of pgt_regs.svh
`timescale 1ns/1ps
`include "pgt_regs.svh"
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_errors++; \
   $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module test_pgt_frame_timing;
   import pgt_pkg::*;
   logic mclk = 1'b0, nrst = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
   pgt_rate_e lane_rate = PGT_RATE_800;
   logic frame_start, frame_end, line_start, line_active, vert_blank, frame_busy;
   logic [15:0] n_back, n_act, n_front, n_tot, len_min, len_max, n_frames;
   int n_errors = 0, samples_checked = 0, seed = 94934;
   logic [7:0] ra [9] = '{`PGT_ADDR_CTL, `PGT_ADDR_ACT_HI, `PGT_ADDR_ACT_LO, `PGT_ADDR_TOT_HI,
      `PGT_ADDR_TOT_LO, `PGT_ADDR_PER_HI, `PGT_ADDR_PER_LO, `PGT_ADDR_VBP, `PGT_ADDR_VFP};
   logic [7:0] re [9] = '{8'h00, `PGT_RST_ACT_HI, `PGT_RST_ACT_LO, `PGT_RST_TOT_HI,
      `PGT_RST_TOT_LO, `PGT_RST_PER_HI, `PGT_RST_PER_LO, `PGT_RST_VBP, `PGT_RST_VFP};

   always #2.5 mclk = ~mclk;

   pgt_frame_timing pgt_frame_timing_inst (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
      .reg_rdata(reg_rdata), .lane_rate(lane_rate), .frame_start(frame_start),
      .frame_end(frame_end), .line_start(line_start), .line_active(line_active),
      .vert_blank(vert_blank), .frame_busy(frame_busy));

   pgt_rx_model pgt_rx_model_inst (.mclk(mclk), .nrst(nrst), .frame_start(frame_start),
      .frame_end(frame_end), .line_start(line_start), .line_active(line_active),
      .vert_blank(vert_blank), .frame_busy(frame_busy), .n_back(n_back), .n_act(n_act),
      .n_front(n_front), .n_tot(n_tot), .len_min(len_min), .len_max(len_max),
      .n_frames(n_frames));

   task complete_run;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   function automatic int rnd(input int n);
      return int'($unsigned($random(seed)) % n);
   endfunction

   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr_en <= 1'b1;
      @(posedge mclk);
      reg_wr_en <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge mclk);
      reg_rd_en <= 1'b0;
      @(negedge mclk);
      v = reg_rdata;
   endtask

   // bounded wait for frame start (idle=0) or for the end of the frame (idle=1)
   task wait_for(input bit idle, input int lim);
      int i;
      for (i = 0; i < lim; i++)
      begin
         @(negedge mclk);
         if (idle ? (frame_busy === 1'b0) : (frame_start === 1'b1))
            break;
      end
      if (i == lim)
      begin
         n_errors++;
         $display("[FAIL] wait timed out");
         complete_run();
      end
   endtask

   // nf frames back to back; enable is cleared right after the last frame start
   task run_frame(input pgt_rate_e r, input logic [7:0] vb, input logic [7:0] vf,
      input logic [15:0] ac, input logic [15:0] tt, input logic [15:0] pp, input int nf);
      logic [15:0] f0, lo, hi;
      int p;
      f0 = n_frames;
      @(posedge mclk);
      lane_rate <= r;
      wr(`PGT_ADDR_ACT_HI, ac[15:8]);
      wr(`PGT_ADDR_ACT_LO, ac[7:0]);
      wr(`PGT_ADDR_TOT_HI, tt[15:8]);
      wr(`PGT_ADDR_TOT_LO, tt[7:0]);
      wr(`PGT_ADDR_PER_HI, pp[15:8]);
      wr(`PGT_ADDR_PER_LO, pp[7:0]);
      wr(`PGT_ADDR_VBP, vb);
      wr(`PGT_ADDR_VFP, vf);
      repeat (4) @(negedge mclk);
      `CHK("no_frame_off", f0, n_frames)
      wr(`PGT_ADDR_CTL, 8'h01);
      wait_for(1'b0, 20);
      for (int j = 1; j < nf; j++)
         wait_for(1'b0, 30000);
      wr(`PGT_ADDR_CTL, 8'h00);
      wait_for(1'b1, 30000);
      repeat (20) @(negedge mclk);
      p = (pp == 16'h0) ? 1 : int'(pp);
      lo = (r == PGT_RATE_400) ? 16'(4 * p) : (r == PGT_RATE_1200) ? 16'(8 * p / 3) : 16'(2 * p);
      hi = lo + ((r == PGT_RATE_1200) ? 16'h1 : 16'h0);
      `CHK("frames", f0 + 16'(nf), n_frames)
      `CHK("back", {8'h00, vb}, n_back)
      `CHK("active", ac, n_act)
      `CHK("front", {8'h00, vf}, n_front)
      `CHK("total", tt, n_tot)
      `CHK("len_min", 1'b1, len_min >= lo && len_min <= hi)
      `CHK("len_max", 1'b1, len_max >= lo && len_max <= hi)
   endtask

   initial
   begin
      logic [7:0] vb, vf, v;
      logic [15:0] ac, tt;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      for (int k = 0; k < 9; k++)
      begin
         rd(ra[k], d);
         `CHK("reset_value", re[k], d)
      end
      // unmapped place swallows writes and reads as zero
      wr(8'h20, 8'h5a);
      rd(8'h20, d);
      `CHK("unmapped", 8'h00, d)
      for (int k = 1; k < 9; k++)
      begin
         v = 8'(rnd(256));
         wr(ra[k], v);
         rd(ra[k], d);
         `CHK("readback", v, d)
      end
      // reset line period, long lines, one active line
      run_frame(PGT_RATE_800, 8'h00, 8'h00, 16'h1, 16'h2,
         {`PGT_RST_PER_HI, `PGT_RST_PER_LO}, 1);
      run_frame(PGT_RATE_1600, 8'h03, 8'h03, 16'h4, 16'ha, 16'h1, 1);
      // two frames back to back: restart on the last line end of the first
      run_frame(PGT_RATE_1200, 8'h01, 8'h01, 16'h2, 16'h6, 16'h2, 2);
      for (int k = 0; k < 12; k++)
      begin
         vb = 8'(rnd(4));
         vf = 8'(rnd(4));
         ac = 16'(1 + rnd(4));
         tt = 16'(vb) + ac + 16'(vf) + 16'(rnd(3));
         if (tt < 16'h2)
            tt = 16'h2;
         run_frame(pgt_rate_e'(k % 4), vb, vf, ac, tt, 16'(2 + rnd(4)), 1);
      end
      complete_run();
   end
endmodule

// ===== src/pgt_frame_timing.sv
// vertical and line timing of the test pattern generator
// assumes an 8-bit indirect register port in the core clock domain and a
// lane rate select that only changes while the generator is stopped
// How it works
// RULE1: each frame carries the 16-bit active line count, reset to 480 lines (0x01, 0xe0).
// RULE2: each frame lasts the 16-bit total line count, blanking lines included.
// RULE3: at 800 Mbps and 1.6 Gbps the line period count is in 10 ns units.
// RULE4: at 1.2 Gbps the line period count is in 13.33 ns units.
// RULE5: at 400 Mbps the line period count is in 20 ns units.
// RULE6: the line period bytes reset to 0x0c and 0x67, 31.75 us in 10 ns units.
// RULE7: the back porch count of blank lines follows frame start, before the first video line.
// RULE8: the front porch count of blank lines follows the last video line, before frame end.
// RULE9: frames are produced only while the enable bit is set; a frame that is running when the bit clears still runs to its last line.
// RULE10: every line takes one line period and fill lines pad the frame to the total.
`timescale 1ns/1ps
`include "pgt_regs.svh"
module pgt_frame_timing (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rdata,
   input wire pgt_pkg::pgt_rate_e lane_rate,
   output logic frame_start,
   output logic frame_end,
   output logic line_start,
   output logic line_active,
   output logic vert_blank,
   output logic frame_busy
);
   import pgt_pkg::*;

   pgt_core_s r_r;
   pgt_core_s r_nxt;
   logic tick;
   logic frame_go;
   logic line_end;
   logic last_line;
   logic [15:0] per_eff;
   logic [15:0] tot_eff;

   function automatic pgt_state_e next_seg(input pgt_state_e cur, input logic [7:0] vbp,
                                           input logic [15:0] act, input logic [7:0] vfp);
      next_seg = S_FILL;
      if (cur == S_IDLE && vbp != 8'h00)
         next_seg = S_BACK;
      else if ((cur == S_IDLE || cur == S_BACK) && act != 16'h0000)
         next_seg = S_ACTIVE;
      else if (cur != S_FRONT && cur != S_FILL && vfp != 8'h00)
         next_seg = S_FRONT;
   endfunction

   function automatic logic [15:0] seg_len(input pgt_state_e cur, input logic [7:0] vbp,
                                           input logic [15:0] act, input logic [7:0] vfp);
      unique case (cur)
         S_BACK: seg_len = {8'h00, vbp};
         S_ACTIVE: seg_len = act;
         S_FRONT: seg_len = {8'h00, vfp};
         S_IDLE, S_FILL: seg_len = 16'hffff;
      endcase
   endfunction

   pgt_unit_tick #(
      .CLK_PS(`PGT_CLK_PS)
   ) u_tick (
      .mclk(mclk),
      .nrst(nrst),
      .clear(frame_go),
      .rate(lane_rate),
      .tick(tick)
   );

   // a zero count would never end a line or a frame; treat it as one
   assign per_eff = (r_r.per_c == 16'h0000) ? 16'h0001 : r_r.per_c;
   assign tot_eff = (r_r.tot_c == 16'h0000) ? 16'h0001 : r_r.tot_c;
   assign line_end = r_r.st != S_IDLE && tick &&
                     ({1'b0, r_r.unit_cnt} + 17'h1 >= {1'b0, per_eff}); // [RULE10]
   assign last_line = {1'b0, r_r.line_idx} + 17'h1 >= {1'b0, tot_eff}; // [RULE2]
   // a cleared enable lets the running frame finish cleanly
   assign frame_go = r_r.en && (r_r.st == S_IDLE || (line_end && last_line)); // [RULE9]

   always_comb
   begin
      r_nxt = r_r;
      r_nxt.fs = 1'b0;
      r_nxt.fe = 1'b0;
      r_nxt.ls = 1'b0;
      if (reg_rd_en)
      begin
         unique case (reg_addr)
            `PGT_ADDR_CTL: r_nxt.rdata = {7'h00, r_r.en};
            `PGT_ADDR_ACT_HI: r_nxt.rdata = r_r.act_hi;
            `PGT_ADDR_ACT_LO: r_nxt.rdata = r_r.act_lo;
            `PGT_ADDR_TOT_HI: r_nxt.rdata = r_r.tot_hi;
            `PGT_ADDR_TOT_LO: r_nxt.rdata = r_r.tot_lo;
            `PGT_ADDR_PER_HI: r_nxt.rdata = r_r.per_hi;
            `PGT_ADDR_PER_LO: r_nxt.rdata = r_r.per_lo;
            `PGT_ADDR_VBP: r_nxt.rdata = r_r.vbp;
            `PGT_ADDR_VFP: r_nxt.rdata = r_r.vfp;
            default: r_nxt.rdata = 8'h00;
         endcase
      end
      if (reg_wr_en)
      begin
         unique case (reg_addr)
            `PGT_ADDR_CTL: r_nxt.en = reg_wdata[`PGT_CTL_EN_BIT]; // [RULE9]
            `PGT_ADDR_ACT_HI: r_nxt.act_hi = reg_wdata;
            `PGT_ADDR_ACT_LO: r_nxt.act_lo = reg_wdata;
            `PGT_ADDR_TOT_HI: r_nxt.tot_hi = reg_wdata;
            `PGT_ADDR_TOT_LO: r_nxt.tot_lo = reg_wdata;
            `PGT_ADDR_PER_HI: r_nxt.per_hi = reg_wdata;
            `PGT_ADDR_PER_LO: r_nxt.per_lo = reg_wdata;
            `PGT_ADDR_VBP: r_nxt.vbp = reg_wdata;
            `PGT_ADDR_VFP: r_nxt.vfp = reg_wdata;
            default: r_nxt.en = r_r.en;
         endcase
      end
      if (tick && r_r.st != S_IDLE)
         r_nxt.unit_cnt = r_r.unit_cnt + 16'h1;
      if (line_end)
      begin
         r_nxt.unit_cnt = 16'h0000;
         r_nxt.line_idx = r_r.line_idx + 16'h1;
         r_nxt.seg_cnt = r_r.seg_cnt + 16'h1;
         if (last_line)
         begin
            // a short total cuts the frame; frame end still goes out
            r_nxt.fe = !r_r.fe_done; // [RULE2]
            r_nxt.fe_done = 1'b1;
            r_nxt.st = S_IDLE;
            r_nxt.busy = 1'b0;
         end
         else
         begin
            r_nxt.ls = 1'b1; // [RULE10]
            if ({1'b0, r_r.seg_cnt} + 17'h1 >=
                {1'b0, seg_len(r_r.st, r_r.vbp_c, r_r.act_c, r_r.vfp_c)})
            begin
               r_nxt.st = next_seg(r_r.st, r_r.vbp_c, r_r.act_c, r_r.vfp_c); // [RULE7] [RULE8]
               r_nxt.seg_cnt = 16'h0000;
               if (r_nxt.st == S_FILL && !r_r.fe_done)
               begin
                  r_nxt.fe = 1'b1; // [RULE8]
                  r_nxt.fe_done = 1'b1;
               end
            end
         end
      end
      if (frame_go)
      begin
         // counts are frozen per frame so that writes never tear a frame
         r_nxt.act_c = {r_r.act_hi, r_r.act_lo}; // [RULE1]
         r_nxt.tot_c = {r_r.tot_hi, r_r.tot_lo}; // [RULE2]
         r_nxt.per_c = {r_r.per_hi, r_r.per_lo};
         r_nxt.vbp_c = r_r.vbp;
         r_nxt.vfp_c = r_r.vfp;
         r_nxt.st = next_seg(S_IDLE, r_r.vbp, {r_r.act_hi, r_r.act_lo}, r_r.vfp); // [RULE7]
         r_nxt.fs = 1'b1;
         r_nxt.ls = 1'b1;
         r_nxt.busy = 1'b1;
         r_nxt.line_idx = 16'h0000;
         r_nxt.seg_cnt = 16'h0000;
         r_nxt.unit_cnt = 16'h0000;
         r_nxt.fe_done = r_nxt.st == S_FILL;
         r_nxt.fe = r_nxt.fe || r_nxt.st == S_FILL;
      end
      r_nxt.lv = r_nxt.st == S_ACTIVE; // [RULE1]
      r_nxt.vb = r_nxt.busy && r_nxt.st != S_ACTIVE;
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         r_r <= '0;
         r_r.st <= S_IDLE;
         r_r.act_hi <= `PGT_RST_ACT_HI; // [RULE1]
         r_r.act_lo <= `PGT_RST_ACT_LO; // [RULE1]
         r_r.tot_hi <= `PGT_RST_TOT_HI;
         r_r.tot_lo <= `PGT_RST_TOT_LO;
         r_r.per_hi <= `PGT_RST_PER_HI; // [RULE6]
         r_r.per_lo <= `PGT_RST_PER_LO; // [RULE6]
         r_r.vbp <= `PGT_RST_VBP;
         r_r.vfp <= `PGT_RST_VFP;
         r_r.en <= `PGT_RST_EN;
      end
      else
         r_r <= r_nxt;
   end

   assign reg_rdata = r_r.rdata;
   assign frame_start = r_r.fs;
   assign frame_end = r_r.fe;
   assign line_start = r_r.ls;
   assign line_active = r_r.lv;
   assign vert_blank = r_r.vb;
   assign frame_busy = r_r.busy;

   // checking helpers, read only by the assertions below
   logic [31:0] cyc_h;
   logic ls_seen_h;
   logic fs_seen_h;
   logic [15:0] fl_h;
   logic [15:0] tot_h;
   logic [15:0] act_h;
   logic [15:0] since_h;
   logic [31:0] per13_lo;

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         cyc_h <= 32'h0;
         ls_seen_h <= 1'b0;
         fs_seen_h <= 1'b0;
         fl_h <= 16'h0;
         tot_h <= 16'h0;
         act_h <= 16'h0;
         since_h <= 16'h0;
      end
      else
      begin
         cyc_h <= r_r.ls ? 32'h1 : cyc_h + 32'h1;
         ls_seen_h <= r_r.ls || (ls_seen_h && r_r.st != S_IDLE);
         fs_seen_h <= r_r.fs || (fs_seen_h && r_r.st != S_IDLE);
         fl_h <= r_r.fs ? 16'h1 : (r_r.ls ? fl_h + 16'h1 : fl_h);
         tot_h <= r_r.fs ? tot_eff : tot_h;
         act_h <= r_r.fs ? {15'h0, r_r.lv} : ((r_r.ls && r_r.lv) ? act_h + 16'h1 : act_h);
         since_h <= (r_r.ls && r_r.lv) ? 16'h0 : (r_r.ls ? since_h + 16'h1 : since_h);
      end
   end

   assign per13_lo = ({16'h0, per_eff} * 32'h8) / 32'h3;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   a_reset_active: assert property (disable iff (1'b0) $rose(nrst) |-> // [RULE1]
      r_r.act_hi == `PGT_RST_ACT_HI && r_r.act_lo == `PGT_RST_ACT_LO)
      else $error("active line reset wrong");
   a_reset_period: assert property (disable iff (1'b0) $rose(nrst) |-> // [RULE6]
      {r_r.per_hi, r_r.per_lo} == {`PGT_RST_PER_HI, `PGT_RST_PER_LO})
      else $error("line period reset wrong");
   a_line_10ns: assert property (r_r.ls && ls_seen_h && // [RULE3]
      (lane_rate == PGT_RATE_800 || lane_rate == PGT_RATE_1600) |->
      cyc_h == {15'h0, per_eff, 1'b0}) else $error("10 ns line period wrong");
   a_line_13ns: assert property (r_r.ls && ls_seen_h && lane_rate == PGT_RATE_1200 |-> // [RULE4]
      cyc_h >= per13_lo && cyc_h <= per13_lo + 32'h1) else $error("13.33 ns period wrong");
   a_line_20ns: assert property (r_r.ls && ls_seen_h && lane_rate == PGT_RATE_400 |-> // [RULE5]
      cyc_h == {14'h0, per_eff, 2'b00}) else $error("20 ns line period wrong");
   a_frame_total: assert property (r_r.fs && fs_seen_h |-> fl_h == tot_h) // [RULE2]
      else $error("frame total lines wrong");
   a_back_porch: assert property ($rose(r_r.lv) && !r_r.fs |-> // [RULE7]
      fl_h == {8'h00, r_r.vbp_c}) else $error("back porch length wrong");
   a_active_lines: assert property (r_r.fe && r_r.ls && !r_r.fs && r_r.st == S_FILL |-> // [RULE1]
      act_h == r_r.act_c) else $error("active line count wrong");
   a_front_porch: assert property (r_r.fe && r_r.ls && !r_r.fs && r_r.st == S_FILL && // [RULE8]
      r_r.act_c != 16'h0 |-> since_h == {8'h00, r_r.vfp_c}) else $error("front porch wrong");
   a_enable_gate: assert property (r_r.st == S_IDLE && !r_r.en && // [RULE9]
      !(reg_wr_en && reg_addr == `PGT_ADDR_CTL && reg_wdata[`PGT_CTL_EN_BIT]) |=>
      !r_r.fs ##1 !r_r.ls) else $error("frame started while disabled");
   a_line_whole: assert property (r_r.fs && !r_r.fe |-> // [RULE10]
      r_r.busy ##1 (!r_r.fs && !r_r.ls)) else $error("frame start not followed by a full line");

endmodule

// ===== src/pgt_unit_tick.sv
// line period unit tick: one pulse per 10, 13.33 or 20 ns unit of the lane rate
// assumes clear is a one-cycle request from the frame sequencer
`timescale 1ns/1ps
`include "pgt_regs.svh"
module pgt_unit_tick #(
   parameter int CLK_PS = `PGT_CLK_PS
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clear,
   input wire pgt_pkg::pgt_rate_e rate,
   output logic tick
);
   import pgt_pkg::*;

   if (CLK_PS < 1 || CLK_PS > `PGT_UNIT_10NS_PS)
   begin : g_chk
      $error("clock period must not exceed the shortest unit");
   end

   pgt_tick_s r_r;
   pgt_tick_s r_nxt;
   logic [15:0] unit;
   logic [15:0] sum;

   // 13.33 ns is not a whole number of cycles: a phase accumulator keeps the
   // average unit exact and jitters each tick by at most one cycle
   always_comb
   begin
      r_nxt = r_r;
      unique case (rate)
         PGT_RATE_400: unit = 16'(`PGT_UNIT_20NS_PS); // [RULE5]
         PGT_RATE_1200: unit = 16'(`PGT_UNIT_13NS_PS); // [RULE4]
         PGT_RATE_800, PGT_RATE_1600: unit = 16'(`PGT_UNIT_10NS_PS); // [RULE3]
      endcase
      // a clear counts as the first cycle of a unit, else the first line of
      // every frame would run one cycle long
      sum = (clear ? 16'h0000 : r_r.acc) + 16'(CLK_PS);
      if (sum >= unit)
      begin
         r_nxt.acc = sum - unit;
         r_nxt.tick = 1'b1;
      end
      else
      begin
         r_nxt.acc = sum;
         r_nxt.tick = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         r_r <= '0;
      else
         r_r <= r_nxt;
   end

   assign tick = r_r.tick;

endmodule
